// ---- core/mcb_params.svh ----
// constants of the main clock, time base and tone block
// assumes the core clock is the oscillator clock; included by bare name
`ifndef MCB_PARAMS_SVH
`define MCB_PARAMS_SVH
// register indices; byte address is four times the index
`define MCB_IDX_CCS 8'h2C
`define MCB_IDX_BEEP 8'h2D
`define MCB_IDX_EVT_STAT 8'h2E
`define MCB_IDX_EVT_MASK 8'h2F
`define MCB_IDX_NONE 8'hFF
// address slices used to turn a byte address into an index
`define MCB_IDX_FIELD 9:2
`define MCB_IDX_UPPER 31:10
`define MCB_IDX_LANE 1:0
`define MCB_HSIZE_WORD 3'h2
// field positions of the clock control/status register
`define MCB_CCS_CLKOUT 7
`define MCB_CCS_DIV_HI 6
`define MCB_CCS_DIV_LO 5
`define MCB_CCS_SLOW 4
`define MCB_CCS_TB_HI 3
`define MCB_CCS_TB_LO 2
`define MCB_CCS_IE 1
`define MCB_CCS_FLAG 0
// event status and mask bit positions
`define MCB_EVT_TB 0
`define MCB_EVT_WAKE 1
// reset values
`define MCB_CCS_RESET_CTL 7'h00
`define MCB_BEEP_RESET 2'h0
`define MCB_EVT_RESET 2'h0
// time base periods in oscillator cycles: 16000, 32000, 80000, 200000
`define MCB_TB_CYC_0 18'h03E80
`define MCB_TB_CYC_1 18'h07D00
`define MCB_TB_CYC_2 18'h13880
`define MCB_TB_CYC_3 18'h30D40
// tone pitches are quoted against an 8 MHz oscillator
`define MCB_OSC_REF_HZ 32'h007A1200
`define MCB_TONE_HZ_1 32'h000007D0
`define MCB_TONE_HZ_2 32'h000003E8
`define MCB_TONE_HZ_3 32'h000001F4
`define MCB_DUTY_SPLIT 32'h00000002
`define MCB_TONE_HALF_1 (`MCB_OSC_REF_HZ / (`MCB_DUTY_SPLIT * `MCB_TONE_HZ_1))
`define MCB_TONE_HALF_2 (`MCB_OSC_REF_HZ / (`MCB_DUTY_SPLIT * `MCB_TONE_HZ_2))
`define MCB_TONE_HALF_3 (`MCB_OSC_REF_HZ / (`MCB_DUTY_SPLIT * `MCB_TONE_HZ_3))
`endif

// ---- core/mcb_pkg.sv ----
// types shared by the clock control block
// assumes nothing beyond the tool's package support
package mcb_pkg;
    // power mode of the part, one-hot
    typedef enum logic [3:0] {
        mcb_st_run = 4'h1,
        mcb_st_wait = 4'h2,
        mcb_st_ahalt = 4'h4,
        mcb_st_halt = 4'h8
    } mcb_power_e;
    typedef logic [1:0] mcb_sel_t;
endpackage

// ---- core/mcb_tone.sv ----
// tone generator: square wave of about half duty on the tone pin
// assumes the clock is the oscillator clock; select changes at any time
`timescale 1ns/100ps
`include "mcb_params.svh"
module mcb_tone #(
    parameter logic [13:0] HALF_1 = 14'(`MCB_TONE_HALF_1),
    parameter logic [13:0] HALF_2 = 14'(`MCB_TONE_HALF_2),
    parameter logic [13:0] HALF_3 = 14'(`MCB_TONE_HALF_3)
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire mcb_pkg::mcb_sel_t i_tone_select,
    input wire logic i_freeze,
    output logic o_tone
);
    import mcb_pkg::*;
    logic [13:0] cnt_reg; // cycles into the current half period

    // half period length for a tone code
    function automatic logic [13:0] f_half(input mcb_sel_t sel);
        case (sel)
            2'h1: f_half = HALF_1;
            2'h2: f_half = HALF_2;
            default: f_half = HALF_3;
        endcase
    endfunction

    // toggle at each half period; >= keeps a shorter new pitch from overrunning
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_reg <= 14'h0000;
            o_tone <= 1'b0;
        end else if (i_freeze) begin
            cnt_reg <= cnt_reg; // oscillator stopped
        end else if (i_tone_select == 2'h0) begin
            cnt_reg <= 14'h0000; // off: pin low
            o_tone <= 1'b0;
        end else if (cnt_reg >= f_half(i_tone_select) - 14'h0001) begin
            cnt_reg <= 14'h0000; // [R12]
            o_tone <= ~o_tone;
        end else begin
            cnt_reg <= cnt_reg + 14'h0001;
        end
    end

    property p_tone_off;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_tone_select == 2'h0 && !i_freeze) |=> !o_tone;
    endproperty
    a_tone_off: assert property (p_tone_off) else $error("tone pin high while tone is off"); // [R12]
endmodule

// ---- core/mcb_top.sv ----
// main clock controller: cpu clock prescaler, clock out, time base, tone
// assumes an AHB-Lite master, one slave; inputs synchronous to i_core_clk
`timescale 1ns/100ps
`include "mcb_params.svh"
// Function
// [R1] time base irq needs enable and unmasked
// [R2] time base wakes wait/active-halt, not halt
// [R3] clock-out bit drives pin, else released
// [R4] clock out stopped during active halt
// [R5] slow divider codes give 2,4,8,16
// [R6] slow bit clear: cpu clock equals oscillator
// [R7] period codes: 16000,32000,80000,200000 cycles
// [R8] new period applies at period end
// [R9] halt with enable enters active halt
// [R10] flag set on period; read clears it
// [R11] software avoids bit set/clear instructions
// [R12] tone codes: off, 2k, 1k, 500 Hz
// [R13] software keeps reserved tone bits zero
// [R14] tone keeps running in active halt
// [R15] registers at 2C/2D, reset zero
// [R16] full halt freezes counter and registers
// [R17] irq follows flag, drops one cycle after
// [R18] rate changes only at divider boundary
module mcb_top #(
    parameter logic [17:0] TB_CYC_0 = `MCB_TB_CYC_0,
    parameter logic [17:0] TB_CYC_1 = `MCB_TB_CYC_1,
    parameter logic [17:0] TB_CYC_2 = `MCB_TB_CYC_2,
    parameter logic [17:0] TB_CYC_3 = `MCB_TB_CYC_3,
    parameter logic [13:0] TONE_HALF_3 = 14'(`MCB_TONE_HALF_3)
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_halt_req,
    input wire logic i_wait_req,
    input wire logic i_wake_ext,
    input wire logic i_irq_mask,
    output logic o_cpu_tick,
    output mcb_pkg::mcb_power_e o_power_mode,
    output logic o_timebase_irq,
    output logic o_event_irq,
    output logic o_clock_out_pin,
    output logic o_clock_out_oe,
    output logic o_tone_pin,
    output logic o_tone_oe
);
    import mcb_pkg::*;
    localparam logic [13:0] TONE_HALF_1 = 14'(`MCB_TONE_HALF_1);
    localparam logic [13:0] TONE_HALF_2 = 14'(`MCB_TONE_HALF_2);

    logic [7:1] ccs_ctl_reg; // control fields of clock_control_status
    logic flag_reg; // timebase_elapsed_flag
    mcb_sel_t beep_reg; // tone_select
    logic [1:0] evt_stat_reg; // sticky events, write one to clear
    logic [1:0] evt_mask_reg; // event enables
    logic wr_pend_reg; // write data phase follows
    logic [7:0] wr_idx_reg; // index of the pending write
    mcb_power_e state_reg; // power mode
    mcb_power_e state_next;
    logic [17:0] tb_cnt_reg; // time base count
    mcb_sel_t tb_act_reg; // period now running
    logic [3:0] div_cnt_reg; // prescaler count
    logic [2:0] act_log_reg; // log2 of the ratio in force
    logic tone_oe_reg;

    // control fields
    logic clock_out_enable;
    mcb_sel_t slow_divider_select;
    logic slow_select;
    mcb_sel_t timebase_period_select;
    logic timebase_irq_enable;
    assign clock_out_enable = ccs_ctl_reg[`MCB_CCS_CLKOUT];
    assign slow_divider_select = ccs_ctl_reg[`MCB_CCS_DIV_HI:`MCB_CCS_DIV_LO];
    assign slow_select = ccs_ctl_reg[`MCB_CCS_SLOW];
    assign timebase_period_select = ccs_ctl_reg[`MCB_CCS_TB_HI:`MCB_CCS_TB_LO];
    assign timebase_irq_enable = ccs_ctl_reg[`MCB_CCS_IE];

    // byte address to register index, out of range or unaligned gives none
    function automatic logic [7:0] f_decode(input logic [31:0] addr);
        f_decode = `MCB_IDX_NONE;
        if (addr[`MCB_IDX_UPPER] == 22'h000000 && addr[`MCB_IDX_LANE] == 2'h0) begin
            f_decode = addr[`MCB_IDX_FIELD];
        end
    endfunction

    // period length in oscillator cycles
    function automatic logic [17:0] f_tb_len(input mcb_sel_t sel);
        case (sel)
            2'h0: f_tb_len = TB_CYC_0;
            2'h1: f_tb_len = TB_CYC_1;
            2'h2: f_tb_len = TB_CYC_2;
            default: f_tb_len = TB_CYC_3;
        endcase
    endfunction

    // last prescaler count for a log2 ratio
    function automatic logic [3:0] f_div_last(input logic [2:0] lg);
        f_div_last = 4'((5'h01 << lg) - 5'h01);
    endfunction

    // bus handshake: zero wait, always okay
    logic acc;
    logic [7:0] acc_idx;
    logic frozen;
    logic rd_ccs;
    logic wr_ok;
    assign acc = i_hsel && i_htrans[1] && i_hready && i_hsize == `MCB_HSIZE_WORD;
    assign acc_idx = f_decode(i_haddr);
    assign frozen = state_reg == mcb_st_ahalt || state_reg == mcb_st_halt; // [R16]
    assign rd_ccs = acc && !i_hwrite && acc_idx == `MCB_IDX_CCS && !frozen;
    assign wr_ok = wr_pend_reg && !frozen;

    // time base terminal count; counter stands still in full halt
    logic tb_term;
    assign tb_term = state_reg != mcb_st_halt && tb_cnt_reg == f_tb_len(tb_act_reg) - 18'h00001;

    // address phase capture and registered read data
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= `MCB_IDX_NONE;
            o_hrdata <= 32'h00000000;
            o_hreadyout <= 1'b0;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1; // never stretches a transfer
            o_hresp <= 1'b0;
            wr_pend_reg <= acc && i_hwrite;
            wr_idx_reg <= acc_idx;
            if (acc && !i_hwrite) begin
                case (acc_idx)
                    `MCB_IDX_CCS: o_hrdata <= {24'h000000, ccs_ctl_reg, flag_reg}; // [R15]
                    `MCB_IDX_BEEP: o_hrdata <= {30'h00000000, beep_reg}; // [R13]
                    `MCB_IDX_EVT_STAT: o_hrdata <= {30'h00000000, evt_stat_reg};
                    `MCB_IDX_EVT_MASK: o_hrdata <= {30'h00000000, evt_mask_reg};
                    default: o_hrdata <= 32'h00000000; // unmapped reads zero
                endcase
            end
        end
    end

    // control registers; writes land in the data phase
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ccs_ctl_reg <= `MCB_CCS_RESET_CTL; // [R15]
            beep_reg <= `MCB_BEEP_RESET;
            evt_mask_reg <= `MCB_EVT_RESET;
        end else if (wr_ok) begin
            case (wr_idx_reg)
                `MCB_IDX_CCS: ccs_ctl_reg <= i_hwdata[7:1]; // flag bit is read only
                `MCB_IDX_BEEP: beep_reg <= i_hwdata[1:0]; // reserved bits dropped [R13]
                `MCB_IDX_EVT_MASK: evt_mask_reg <= i_hwdata[1:0];
                default: ccs_ctl_reg <= ccs_ctl_reg;
            endcase
        end
    end

    // elapsed flag: read of the register clears, a new period wins
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            flag_reg <= 1'b0;
        end else if (tb_term) begin
            flag_reg <= 1'b1; // [R10]
        end else if (rd_ccs) begin
            flag_reg <= 1'b0; // [R10]
        end
    end

    // sticky events, set wins over a write-one clear
    logic wake_evt;
    logic [1:0] evt_clr;
    assign wake_evt = state_reg != mcb_st_run && state_next == mcb_st_run;
    assign evt_clr = (wr_ok && wr_idx_reg == `MCB_IDX_EVT_STAT) ? i_hwdata[1:0] : 2'h0;
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            evt_stat_reg <= `MCB_EVT_RESET;
        end else begin
            evt_stat_reg[`MCB_EVT_TB] <= tb_term || (evt_stat_reg[`MCB_EVT_TB] && !evt_clr[`MCB_EVT_TB]);
            evt_stat_reg[`MCB_EVT_WAKE] <= wake_evt || (evt_stat_reg[`MCB_EVT_WAKE] && !evt_clr[`MCB_EVT_WAKE]);
        end
    end

    // time base: selection change waits for the running period to end
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tb_cnt_reg <= 18'h00000;
            tb_act_reg <= 2'h0;
        end else if (state_reg == mcb_st_halt) begin
            tb_cnt_reg <= tb_cnt_reg; // [R16]
        end else if (tb_term) begin
            tb_cnt_reg <= 18'h00000; // [R7]
            tb_act_reg <= timebase_period_select; // [R8]
        end else begin
            tb_cnt_reg <= tb_cnt_reg + 18'h00001;
        end
    end

    // power mode sequencing
    logic tb_wake;
    assign tb_wake = flag_reg && timebase_irq_enable;
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            mcb_st_run: begin
                if (i_halt_req) begin
                    state_next = timebase_irq_enable ? mcb_st_ahalt : mcb_st_halt; // [R9]
                end else if (i_wait_req) begin
                    state_next = mcb_st_wait;
                end
            end
            mcb_st_wait, mcb_st_ahalt: begin
                if (i_wake_ext || tb_wake) begin
                    state_next = mcb_st_run; // [R2]
                end
            end
            mcb_st_halt: begin
                if (i_wake_ext) begin
                    state_next = mcb_st_run; // time base cannot wake here [R2]
                end
            end
            default: state_next = mcb_st_run;
        endcase
    end
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg <= mcb_st_run;
        end else begin
            state_reg <= state_next;
        end
    end
    assign o_power_mode = state_reg;

    // cpu clock prescaler; a new ratio is taken only on a tick so no short pulse
    logic clk_run;
    assign clk_run = state_reg == mcb_st_run || state_reg == mcb_st_wait;
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            div_cnt_reg <= 4'h0;
            act_log_reg <= 3'h0;
            o_cpu_tick <= 1'b0;
        end else if (!clk_run) begin
            o_cpu_tick <= 1'b0; // no cpu clock in either halt
        end else if (div_cnt_reg == f_div_last(act_log_reg)) begin
            div_cnt_reg <= 4'h0;
            o_cpu_tick <= 1'b1; // [R5] [R6]
            act_log_reg <= slow_select ? {1'b0, slow_divider_select} + 3'h1 : 3'h0; // [R18]
        end else begin
            div_cnt_reg <= div_cnt_reg + 4'h1;
            o_cpu_tick <= 1'b0;
        end
    end

    // clock out: toggles per cpu tick, so it runs at half the cpu tick rate
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_clock_out_pin <= 1'b0;
            o_clock_out_oe <= 1'b0;
        end else begin
            o_clock_out_oe <= clock_out_enable; // [R3]
            if (!clock_out_enable) begin
                o_clock_out_pin <= 1'b0;
            end else if (clk_run && o_cpu_tick) begin
                o_clock_out_pin <= ~o_clock_out_pin; // frozen in active halt [R4]
            end
        end
    end

    // interrupt lines, registered so they drop one cycle after the cause
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_timebase_irq <= 1'b0;
            o_event_irq <= 1'b0;
            tone_oe_reg <= 1'b0;
        end else begin
            o_timebase_irq <= flag_reg && timebase_irq_enable && !i_irq_mask; // [R1] [R17]
            o_event_irq <= |(evt_stat_reg & evt_mask_reg);
            tone_oe_reg <= beep_reg != 2'h0;
        end
    end
    assign o_tone_oe = tone_oe_reg;

    // tone generator stops only with the oscillator in full halt
    mcb_tone #(
        .HALF_1(TONE_HALF_1),
        .HALF_2(TONE_HALF_2),
        .HALF_3(TONE_HALF_3)
    ) u_tone (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_tone_select(beep_reg),
        .i_freeze(state_reg == mcb_st_halt), // [R14]
        .o_tone(o_tone_pin)
    );

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    logic run_st;
    assign run_st = clk_run;
    // a tick that closes three quiet cycles; looks back so the next ratio cannot leak in
    sequence s_gap4;
        o_cpu_tick && !$past(o_cpu_tick) && !$past(o_cpu_tick, 2) && !$past(o_cpu_tick, 3);
    endsequence
    sequence s_run5;
        run_st [*5];
    endsequence
    property p_irq_gate;
        (flag_reg && timebase_irq_enable && !i_irq_mask) |=> o_timebase_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq missing"); // [R1]
    property p_irq_drop;
        (!flag_reg || !timebase_irq_enable || i_irq_mask) |=> !o_timebase_irq;
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("irq stuck"); // [R17]
    property p_ahalt_enter;
        (state_reg == mcb_st_run && i_halt_req && timebase_irq_enable) |=> state_reg == mcb_st_ahalt;
    endproperty
    a_ahalt_enter: assert property (p_ahalt_enter) else $error("no active halt"); // [R9]
    property p_halt_hold;
        (state_reg == mcb_st_halt && !i_wake_ext) |=> state_reg == mcb_st_halt && $stable(tb_cnt_reg);
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halt left or counted"); // [R2] [R16]
    property p_ahalt_wake;
        (state_reg == mcb_st_ahalt && tb_wake) |=> state_reg == mcb_st_run;
    endproperty
    a_ahalt_wake: assert property (p_ahalt_wake) else $error("no wake"); // [R2]
    property p_clkout_oe;
        !clock_out_enable |=> !o_clock_out_oe && !o_clock_out_pin;
    endproperty
    a_clkout_oe: assert property (p_clkout_oe) else $error("pin not released"); // [R3]
    property p_clkout_ahalt;
        (state_reg == mcb_st_ahalt) |=> $stable(o_clock_out_pin);
    endproperty
    a_clkout_ahalt: assert property (p_clkout_ahalt) else $error("clock out ran"); // [R4]
    property p_normal_rate;
        (act_log_reg == 3'h0 && run_st) ##1 (act_log_reg == 3'h0 && run_st) |-> o_cpu_tick;
    endproperty
    a_normal_rate: assert property (p_normal_rate) else $error("tick missing"); // [R6]
    property p_div4_gap;
        (o_cpu_tick && act_log_reg == 3'h2 && run_st) ##0 s_run5 |-> s_gap4;
    endproperty
    a_div4_gap: assert property (p_div4_gap) else $error("bad divide by 4"); // [R5]
    property p_ratio_switch;
        !(run_st && div_cnt_reg == f_div_last(act_log_reg)) |=> $stable(act_log_reg);
    endproperty
    a_ratio_switch: assert property (p_ratio_switch) else $error("ratio mid period"); // [R18]
    property p_tb_switch;
        !tb_term |=> $stable(tb_act_reg);
    endproperty
    a_tb_switch: assert property (p_tb_switch) else $error("period changed early"); // [R8]
    property p_flag_rw;
        (tb_term |=> flag_reg) and ((rd_ccs && !tb_term) |=> !flag_reg);
    endproperty
    a_flag_rw: assert property (p_flag_rw) else $error("flag set/clear wrong"); // [R10]
endmodule

// ---- verification/mcb_cpu_model.sv ----
// cpu-side partner model: issues halt and wait pulses, counts cpu ticks
// assumes the bench drives i_cmd for one cycle per instruction
`timescale 1ns/100ps
module mcb_cpu_model (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_cpu_tick,
    input wire mcb_pkg::mcb_power_e i_power_mode,
    input wire logic [1:0] i_cmd,
    output logic o_halt_req,
    output logic o_wait_req,
    output logic [31:0] o_tick_count
);
    import mcb_pkg::*;
    // a sleeping cpu executes nothing, so requests only leave the run state
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_halt_req <= 1'b0;
            o_wait_req <= 1'b0;
        end else begin
            o_halt_req <= (i_cmd == 2'h1) && (i_power_mode == mcb_st_run);
            o_wait_req <= (i_cmd == 2'h2) && (i_power_mode == mcb_st_run);
        end
    end
    // tick count stands for cpu work done; the bench compares spans of it
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_tick_count <= 32'h00000000;
        end else if (i_cpu_tick) begin
            o_tick_count <= o_tick_count + 32'h00000001;
        end
    end
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the clock control block with shortened periods
// assumes one ahb-lite slave whose hreadyout feeds hready
`timescale 1ns/100ps
module tb;
    import mcb_pkg::*;
    // byte address is four times the register index
    localparam logic [31:0] A_CCS = 32'h000000B0;
    localparam logic [31:0] A_BEEP = 32'h000000B4;
    localparam logic [31:0] A_STAT = 32'h000000B8;
    localparam logic [31:0] A_MASK = 32'h000000BC;
    int per [4] = '{20, 30, 40, 50}; // period model, same as the parameters
    logic clk, rst, hsel, hwrite, wake, imask, tone_q, cko_q;
    logic [1:0] htrans, cmd;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd, nt;
    logic hready, hresp, tick, tbirq, evirq, cko, ckoe, tone, toneoe, hreq, wreq;
    mcb_power_e mode;
    int bad_count, total_checks, n_tone, n_cko, r0, r1, a, b, c;
    mcb_top #(.TB_CYC_0(18'h00014), .TB_CYC_1(18'h0001E), .TB_CYC_2(18'h00028), .TB_CYC_3(18'h00032),
        .TONE_HALF_3(14'h0010)) u_mcb_top (.i_core_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_halt_req(hreq), .i_wait_req(wreq),
        .i_wake_ext(wake), .i_irq_mask(imask), .o_cpu_tick(tick), .o_power_mode(mode), .o_timebase_irq(tbirq),
        .o_event_irq(evirq), .o_clock_out_pin(cko), .o_clock_out_oe(ckoe), .o_tone_pin(tone), .o_tone_oe(toneoe));
    mcb_cpu_model u_mcb_cpu_model (.i_core_clk(clk), .i_sys_rst(rst), .i_cpu_tick(tick), .i_power_mode(mode),
        .i_cmd(cmd), .o_halt_req(hreq), .o_wait_req(wreq), .o_tick_count(nt));
    // 200 mhz core clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // pin edges counted on the falling edge, where outputs have settled
    always @(negedge clk) begin
        if (tone !== tone_q) n_tone++;
        if (cko !== cko_q) n_cko++;
        tone_q = tone;
        cko_q = cko;
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // single word transfer: hold address phase, then data phase, until hready
    task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= ad;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    // time of the next rising edge of the event interrupt
    task automatic wait_rise(output int t);
        while (evirq !== 1'b0) @(posedge clk);
        while (evirq !== 1'b1) @(posedge clk);
        t = int'($time);
    endtask
    task automatic op(input logic [1:0] k);
        cmd <= k;
        @(posedge clk);
        cmd <= 2'h0;
        repeat (3) @(posedge clk);
    endtask
    task automatic wake_wait(input int lim);
        b = 0;
        while (mode !== mcb_st_run && b < lim) begin
            @(posedge clk);
            b++;
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard, well above the fewer than two thousand cycles the tests need
    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        report_and_stop;
    end
    initial begin
        {hsel, hwrite, wake, imask, htrans, cmd, hsize, haddr, hwdata} = '0;
        rst = 1'b1;
        a = $urandom(32'hB5F6);
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        bus(1'b0, A_CCS, $urandom(), rd); chk("ccs_reset", rd, 32'h0);
        bus(1'b0, A_BEEP, $urandom(), rd); chk("beep_reset", rd, 32'h0);
        bus(1'b0, 32'h00000000, $urandom(), rd); chk("unmapped", rd, 32'h0);
        chk("hresp", hresp, 0);
        // divide ratios 1,2,4,8,16 with clock out on; random settle time
        for (a = 0; a < 5; a++) begin
            c = (a == 0) ? 32'h80 : (32'h90 | ((a - 1) << 5));
            bus(1'b1, A_CCS, c, rd);
            repeat (40 + $urandom_range(7)) @(posedge clk);
            b = nt;
            r0 = n_cko;
            repeat (64) @(posedge clk);
            chk("ticks", nt - b, 64 >> a);
            chk("clkout_edges", n_cko - r0, 64 >> a);
            chk("clkout_oe", ckoe, 1);
        end
        bus(1'b1, A_CCS, 32'h0, rd);
        repeat (2) @(posedge clk);
        chk("clkout_off", {ckoe, cko}, 0);
        // every tone code; reserved bits stay zero on writes
        for (a = 0; a < 4; a++) begin
            bus(1'b1, A_BEEP, a, rd);
            repeat (2) @(posedge clk);
            chk("tone_oe", toneoe, a != 0);
            bus(1'b0, A_BEEP, $urandom(), rd); chk("beep_rw", rd, a);
        end
        b = n_tone;
        repeat (320) @(posedge clk);
        chk("tone_edges", n_tone - b, 20);
        // period codes: old period finishes before the new one applies
        bus(1'b1, A_MASK, 32'h1, rd);
        // two clears: at most one can meet a period end, so the next rise marks a real one
        bus(1'b1, A_STAT, 32'h1, rd);
        bus(1'b1, A_STAT, 32'h1, rd);
        wait_rise(r0);
        for (a = 1; a < 5; a++) begin
            c = a % 4;
            bus(1'b1, A_STAT, 32'h1, rd);
            bus(1'b1, A_CCS, c << 2, rd);
            wait_rise(r1); chk("old_period", r1 - r0, per[(a - 1) % 4] * 5);
            bus(1'b1, A_STAT, 32'h1, rd);
            wait_rise(r0); chk("new_period", r0 - r1, per[c] * 5);
        end
        // plain reads only, so the flag is never cleared by a bit operation
        bus(1'b0, A_CCS, $urandom(), rd); chk("flag_set", rd & 32'h1, 1);
        bus(1'b0, A_CCS, 32'h0, rd); chk("flag_clear", rd & 32'h1, 0);
        imask <= 1'b1;
        bus(1'b1, A_CCS, 32'h0E, rd);
        bus(1'b1, A_STAT, 32'h1, rd);
        wait_rise(r0);
        repeat (2) @(posedge clk);
        chk("irq_masked", tbirq, 0);
        imask <= 1'b0;
        repeat (2) @(posedge clk);
        chk("irq_on", tbirq, 1);
        bus(1'b0, A_CCS, 32'h0, rd);
        repeat (2) @(posedge clk);
        chk("irq_drop", tbirq, 0);
        // active halt: ticks and clock out stop, tone runs, period wakes
        bus(1'b1, A_CCS, 32'h8E, rd);
        bus(1'b1, A_STAT, 32'h1, rd);
        wait_rise(r0);
        bus(1'b0, A_CCS, 32'h0, rd);
        op(2'h1);
        chk("ahalt", mode, mcb_st_ahalt);
        b = nt;
        r1 = n_tone;
        c = cko;
        repeat (32) @(posedge clk);
        chk("ahalt_ticks", nt - b, 0);
        chk("ahalt_clkout", cko, c);
        chk("ahalt_tone", n_tone - r1, 2);
        wake_wait(60);
        chk("ahalt_wake", mode, mcb_st_run);
        // full halt: time base cannot wake, everything frozen
        bus(1'b1, A_CCS, 32'h0C, rd);
        op(2'h1);
        chk("halt", mode, mcb_st_halt);
        b = nt;
        r1 = n_tone;
        repeat (120) @(posedge clk);
        chk("halt_stays", mode, mcb_st_halt);
        chk("halt_ticks", nt - b, 0);
        chk("halt_tone", n_tone - r1, 0);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        repeat (3) @(posedge clk);
        chk("halt_wake", mode, mcb_st_run);
        // wait mode: ticks go on, time base wakes
        bus(1'b1, A_CCS, 32'h0E, rd);
        bus(1'b0, A_CCS, 32'h0, rd);
        op(2'h2);
        chk("wait", mode, mcb_st_wait);
        b = nt;
        repeat (16) @(posedge clk);
        chk("wait_ticks", nt - b, 16);
        wake_wait(80);
        chk("wait_wake", mode, mcb_st_run);
        // every wake so far must have left its sticky event bit
        bus(1'b0, A_STAT, $urandom(), rd); chk("wake_evt", rd & 32'h2, 32'h2);
        report_and_stop;
    end
endmodule
